// ===== logic/e3rxo_top.sv
// receive overhead byte and error count register group
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "e3rxo_defines.svh"

module e3rxo_top
    import e3rxo_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [`E3RXO_ADDR_W-1:0] ADDR,
    input wire logic [`E3RXO_DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [`E3RXO_DATA_W-1:0] RDATA,
    input wire e3rxo_line_type LINE_IN,
    input wire logic MONITOR_LATCH_STROBE,
    output logic IRQ
);

    // =====================================
    // address decode
    function automatic e3rxo_sel_type e3rxo_decode(input logic [`E3RXO_ADDR_W-1:0] a);
        e3rxo_sel_type s;
        s = SEL_NONE;
        unique case (a)
            `E3RXO_ADDR_NRGC: s = SEL_NRGC;
            `E3RXO_ADDR_FRM_CNT: s = SEL_FRM;
            `E3RXO_ADDR_PAR_CNT: s = SEL_PAR;
            `E3RXO_ADDR_REI_CNT: s = SEL_REI;
            `E3RXO_ADDR_STATUS: s = SEL_STAT;
            `E3RXO_ADDR_MASK: s = SEL_MASK;
            `E3RXO_ADDR_CTRL: s = SEL_CTRL;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    e3rxo_sel_type wr_sel;
    e3rxo_sel_type rd_sel;

    assign wr_sel = WR ? e3rxo_decode(ADDR) : SEL_NONE;
    assign rd_sel = RD ? e3rxo_decode(ADDR) : SEL_NONE;

    // =====================================
    // overhead bytes
    logic [`E3RXO_DATA_W-1:0] nr_gc_reg;
    logic nr_change;
    logic gc_change;

    assign nr_change = LINE_IN.ovh_valid &&
        (LINE_IN.received_nr_byte != nr_gc_reg[`E3RXO_NR_HI:`E3RXO_NR_LO]);
    assign gc_change = LINE_IN.ovh_valid &&
        (LINE_IN.received_gc_byte != nr_gc_reg[`E3RXO_GC_HI:`E3RXO_GC_LO]);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            nr_gc_reg <= `E3RXO_RST_REG;
        end else if (CE && LINE_IN.ovh_valid) begin
            nr_gc_reg[`E3RXO_GC_HI:`E3RXO_GC_LO] <= LINE_IN.received_gc_byte;
            nr_gc_reg[`E3RXO_NR_HI:`E3RXO_NR_LO] <= LINE_IN.received_nr_byte;
        end
    end

    // =====================================
    // error counters
    logic [`E3RXO_NUM_CNT-1:0] err_event;
    logic [`E3RXO_NUM_CNT-1:0] cnt_nonzero;
    logic [`E3RXO_CNT_W-1:0] cnt_reg [`E3RXO_NUM_CNT];

    assign err_event = {LINE_IN.remote_err, LINE_IN.parity_err, LINE_IN.framing_err};

    genvar gi;
    generate
        for (gi = 0; gi < `E3RXO_NUM_CNT; gi++) begin : g_cnt
            // index 0 framing, 1 parity, 2 remote error
            e3rxo_err_counter u_cnt (
                .clk(CLK),
                .rst_n(RST_N),
                .ce(CE),
                .event_in(err_event[gi]),
                .latch_in(MONITOR_LATCH_STROBE),
                .count_reg(cnt_reg[gi]),
                .latch_nonzero(cnt_nonzero[gi])
            );
        end
    endgenerate

    // =====================================
    // interrupt status, mask and control
    logic [`E3RXO_DATA_W-1:0] status_reg;
    logic [`E3RXO_DATA_W-1:0] status_next;
    logic [`E3RXO_DATA_W-1:0] status_set;
    logic [`E3RXO_DATA_W-1:0] status_clr;
    logic [`E3RXO_DATA_W-1:0] mask_reg;
    logic [`E3RXO_DATA_W-1:0] ctrl_reg;

    always_comb begin
        status_set = `E3RXO_RST_REG;
        status_set[`E3RXO_ST_FRM_CNT] = cnt_nonzero[0];
        status_set[`E3RXO_ST_PAR_CNT] = cnt_nonzero[1];
        status_set[`E3RXO_ST_REI_CNT] = cnt_nonzero[2];
        status_set[`E3RXO_ST_NR_CHG] = nr_change;
        status_set[`E3RXO_ST_GC_CHG] = gc_change;
        status_set[`E3RXO_ST_FRM_EVT] = err_event[0];
        status_set[`E3RXO_ST_PAR_EVT] = err_event[1];
        status_set[`E3RXO_ST_REI_EVT] = err_event[2];
    end

    // set wins over write-one-to-clear
    assign status_clr = (wr_sel == SEL_STAT) ? WDATA : `E3RXO_RST_REG;
    assign status_next = ((status_reg & ~status_clr) | status_set) & `E3RXO_ST_USED;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            status_reg <= `E3RXO_RST_REG;
        end else if (CE) begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mask_reg <= `E3RXO_RST_REG;
        end else if (CE && wr_sel == SEL_MASK) begin
            mask_reg <= WDATA & `E3RXO_ST_USED;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_reg <= `E3RXO_RST_REG;
        end else if (CE && wr_sel == SEL_CTRL) begin
            ctrl_reg <= WDATA & `E3RXO_CTRL_USED;
        end
    end

    // irq needs latched bit, its enable and the port summary enable
    assign IRQ = ctrl_reg[`E3RXO_CTRL_PSUM] && (|(status_reg & mask_reg));

    // =====================================
    // read port
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= `E3RXO_RST_REG;
        end else if (CE) begin
            unique case (rd_sel)
                SEL_NRGC: RDATA <= nr_gc_reg;
                SEL_FRM: RDATA <= cnt_reg[0];
                SEL_PAR: RDATA <= cnt_reg[1];
                SEL_REI: RDATA <= cnt_reg[2];
                SEL_STAT: RDATA <= status_reg;
                SEL_MASK: RDATA <= mask_reg;
                SEL_CTRL: RDATA <= ctrl_reg;
                SEL_NONE: RDATA <= `E3RXO_RST_REG;
            endcase
        end
    end

    // =====================================
    // checks
    property p_gc_upper;
        @(posedge CLK) disable iff (!RST_N)
        (CE && LINE_IN.ovh_valid) |=>
            (nr_gc_reg[15:8] == $past(LINE_IN.received_gc_byte));
    endproperty
    a_gc_upper: assert property (p_gc_upper)
        else $error("gc byte not in upper byte");

    property p_nr_lower;
        @(posedge CLK) disable iff (!RST_N)
        (CE && LINE_IN.ovh_valid) |=>
            (nr_gc_reg[7:0] == $past(LINE_IN.received_nr_byte));
    endproperty
    a_nr_lower: assert property (p_nr_lower)
        else $error("nr byte not in lower byte");

    property p_read_nrgc;
        @(posedge CLK) disable iff (!RST_N)
        (CE && RD && ADDR == `E3RXO_ADDR_NRGC) |=> (RDATA == $past(nr_gc_reg));
    endproperty
    a_read_nrgc: assert property (p_read_nrgc)
        else $error("nr/gc read data wrong");

    property p_frm_count;
        @(posedge CLK) disable iff (!RST_N)
        (CE && MONITOR_LATCH_STROBE) ##1 (CE && MONITOR_LATCH_STROBE && !LINE_IN.framing_err)
            |=> (cnt_reg[0] == {15'h0000, $past(LINE_IN.framing_err, 2)});
    endproperty
    a_frm_count: assert property (p_frm_count)
        else $error("framing count wrong over one-cycle interval");

    property p_read_par;
        @(posedge CLK) disable iff (!RST_N)
        (CE && RD && ADDR == `E3RXO_ADDR_PAR_CNT) |=> (RDATA == $past(cnt_reg[1]));
    endproperty
    a_read_par: assert property (p_read_par)
        else $error("parity count read data wrong");

    property p_read_rei;
        @(posedge CLK) disable iff (!RST_N)
        (CE && RD && ADDR == `E3RXO_ADDR_REI_CNT) |=> (RDATA == $past(cnt_reg[2]));
    endproperty
    a_read_rei: assert property (p_read_rei)
        else $error("remote error count read data wrong");

    property p_frm_stable;
        @(posedge CLK) disable iff (!RST_N)
        !MONITOR_LATCH_STROBE [*2] |-> $stable(cnt_reg[0]);
    endproperty
    a_frm_stable: assert property (p_frm_stable)
        else $error("framing count moved between strobes");

    property p_irq_frm;
        @(posedge CLK) disable iff (!RST_N)
        (status_reg[0] && mask_reg[0] && ctrl_reg[0]) |-> IRQ;
    endproperty
    a_irq_frm: assert property (p_irq_frm)
        else $error("framing count irq missing");

    property p_irq_psum;
        @(posedge CLK) disable iff (!RST_N)
        !ctrl_reg[0] |-> !IRQ;
    endproperty
    a_irq_psum: assert property (p_irq_psum)
        else $error("irq raised without port summary enable");

    property p_set_wins;
        @(posedge CLK) disable iff (!RST_N)
        (CE && LINE_IN.framing_err && WR && ADDR == `E3RXO_ADDR_STATUS && WDATA[8])
            |=> status_reg[8];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost against status clear");

    property p_unmapped;
        @(posedge CLK) disable iff (!RST_N)
        (CE && RD && e3rxo_decode(ADDR) == SEL_NONE) |=> (RDATA == 16'h0000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

endmodule // e3rxo_top

// ===== shared/e3rxo_defines.svh
// register offsets, field positions, reset values and widths
`ifndef E3RXO_DEFINES_SVH
`define E3RXO_DEFINES_SVH

`define E3RXO_ADDR_W 10
`define E3RXO_DATA_W 16
`define E3RXO_CNT_W 16
`define E3RXO_NUM_CNT 3

`define E3RXO_ADDR_NRGC 10'h132
`define E3RXO_ADDR_FRM_CNT 10'h134
`define E3RXO_ADDR_PAR_CNT 10'h136
`define E3RXO_ADDR_REI_CNT 10'h138
`define E3RXO_ADDR_STATUS 10'h13A
`define E3RXO_ADDR_MASK 10'h13C
`define E3RXO_ADDR_CTRL 10'h13E

`define E3RXO_GC_HI 15
`define E3RXO_GC_LO 8
`define E3RXO_NR_HI 7
`define E3RXO_NR_LO 0

`define E3RXO_ST_FRM_CNT 0
`define E3RXO_ST_PAR_CNT 1
`define E3RXO_ST_REI_CNT 2
`define E3RXO_ST_NR_CHG 6
`define E3RXO_ST_GC_CHG 7
`define E3RXO_ST_FRM_EVT 8
`define E3RXO_ST_PAR_EVT 9
`define E3RXO_ST_REI_EVT 10
`define E3RXO_ST_USED 16'h07C7

`define E3RXO_CTRL_PSUM 0
`define E3RXO_CTRL_USED 16'h0001

`define E3RXO_RST_REG 16'h0000
`define E3RXO_CNT_MAX 16'hFFFF

`endif

// ===== shared/e3rxo_pkg.sv
// types shared by the receive overhead counter block
package e3rxo_pkg;

    // line side events and overhead bytes
    typedef struct packed {
        logic framing_err;
        logic parity_err;
        logic remote_err;
        logic ovh_valid;
        logic [7:0] received_nr_byte;
        logic [7:0] received_gc_byte;
    } e3rxo_line_type;

    // one-hot register select
    typedef enum logic [7:0] {
        SEL_NONE = 8'h01,
        SEL_NRGC = 8'h02,
        SEL_FRM = 8'h04,
        SEL_PAR = 8'h08,
        SEL_REI = 8'h10,
        SEL_STAT = 8'h20,
        SEL_MASK = 8'h40,
        SEL_CTRL = 8'h80
    } e3rxo_sel_type;

endpackage

// ===== logic/e3rxo_err_counter.sv
// error accumulator with latched count register
`timescale 1ns/10ps
`include "e3rxo_defines.svh"

module e3rxo_err_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic event_in,
    input wire logic latch_in,
    output logic [`E3RXO_CNT_W-1:0] count_reg,
    output logic latch_nonzero
);

    logic [`E3RXO_CNT_W-1:0] acc_reg;

    // =====================================
    // accumulator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_reg <= `E3RXO_RST_REG;
        end else if (ce) begin
            if (latch_in) begin
                acc_reg <= {{(`E3RXO_CNT_W-1){1'b0}}, event_in};
            end else if (event_in && acc_reg != `E3RXO_CNT_MAX) begin
                acc_reg <= acc_reg + 16'h0001;
            end
        end
    end

    // =====================================
    // visible count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= `E3RXO_RST_REG;
        end else if (ce && latch_in) begin
            count_reg <= acc_reg;
        end
    end

    assign latch_nonzero = latch_in && (acc_reg != `E3RXO_RST_REG);

    // =====================================
    // checks
    property p_cnt_transfer;
        @(posedge clk) disable iff (!rst_n)
        (ce && latch_in) |=> (count_reg == $past(acc_reg));
    endproperty
    a_cnt_transfer: assert property (p_cnt_transfer)
        else $error("count not transferred on latch strobe");

    property p_acc_restart;
        @(posedge clk) disable iff (!rst_n)
        (ce && latch_in) |=> (acc_reg == {15'h0000, $past(event_in)});
    endproperty
    a_acc_restart: assert property (p_acc_restart)
        else $error("accumulator did not restart keeping coincident event");

    property p_cnt_stable;
        @(posedge clk) disable iff (!rst_n)
        !(ce && latch_in) |=> $stable(count_reg);
    endproperty
    a_cnt_stable: assert property (p_cnt_stable)
        else $error("count changed without latch strobe");

endmodule // e3rxo_err_counter

// ===== testbench/e3rxo_line_model.sv
// far end line equipment model driving events and overhead bytes
`timescale 1ns/10ps

module e3rxo_line_model
    import e3rxo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output e3rxo_line_type line_out
);
    initial line_out = '0;

    // =========================================
    // error pulses, one event per pulse
    task automatic burst(input logic [2:0] kind, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            line_out.framing_err <= kind[2];
            line_out.parity_err <= kind[1];
            line_out.remote_err <= kind[0];
            @(posedge clk);
            line_out.framing_err <= 1'b0;
            line_out.parity_err <= 1'b0;
            line_out.remote_err <= 1'b0;
        end
    endtask

    // =========================================
    // one frame of overhead, bytes garbled outside it
    task automatic send_ovh(input logic [7:0] nr, input logic [7:0] gc);
        @(posedge clk);
        line_out.ovh_valid <= 1'b1;
        line_out.received_nr_byte <= nr;
        line_out.received_gc_byte <= gc;
        @(posedge clk);
        line_out.ovh_valid <= 1'b0;
        line_out.received_nr_byte <= ~nr;
        line_out.received_gc_byte <= ~gc;
    endtask
endmodule // e3rxo_line_model

// ===== testbench/e3_g832_rx_overhead_counters_tb_top.sv
// self-checking bench for the receive overhead counter block
`timescale 1ns/10ps
`include "e3rxo_defines.svh"

module e3_g832_rx_overhead_counters_tb_top
    import e3rxo_pkg::*;
;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic CE = 1'b1;
    logic [9:0] ADDR = '0;
    logic [15:0] WDATA = '0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic MONITOR_LATCH_STROBE = 1'b0;
    logic [15:0] RDATA;
    logic IRQ;
    e3rxo_line_type LINE_IN;
    int n_errors = 0;
    int samples_checked = 0;

    initial begin
        forever #10 CLK = ~CLK;
    end

    e3rxo_top DUT (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .LINE_IN(LINE_IN), .MONITOR_LATCH_STROBE(MONITOR_LATCH_STROBE), .IRQ(IRQ));
    e3rxo_line_model far_end (.clk(CLK), .rst_n(RST_N), .line_out(LINE_IN));

    // =========================================
    // compare, access and verdict tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask

    task automatic rd_chk(input string what, input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        reg_rd(a, d);
        check(what, d, exp);
    endtask

    task automatic strobe();
        @(posedge CLK);
        MONITOR_LATCH_STROBE <= 1'b1;
        @(posedge CLK);
        MONITOR_LATCH_STROBE <= 1'b0;
    endtask

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // =========================================
    // watchdog
    initial begin
        #100us;
        n_errors++;
        summarize();
    end

    // =========================================
    // test sequence
    initial begin
        repeat (3) @(posedge CLK);
        RST_N <= 1'b1;
        rd_chk("nrgc reset", `E3RXO_ADDR_NRGC, 16'h0000);
        rd_chk("frm reset", `E3RXO_ADDR_FRM_CNT, 16'h0000);
        rd_chk("par reset", `E3RXO_ADDR_PAR_CNT, 16'h0000);
        rd_chk("rei reset", `E3RXO_ADDR_REI_CNT, 16'h0000);
        rd_chk("unmapped", 10'h100, 16'h0000);
        reg_wr(`E3RXO_ADDR_FRM_CNT, 16'hBEEF);
        rd_chk("frm read only", `E3RXO_ADDR_FRM_CNT, 16'h0000);
        $display("test reset and access done");
        far_end.send_ovh(8'hA5, 8'h3C);
        rd_chk("nrgc bytes", `E3RXO_ADDR_NRGC, 16'h3CA5);
        $display("test overhead bytes done");
        far_end.burst(3'b111, 1);
        far_end.burst(3'b110, 1);
        far_end.burst(3'b100, 1);
        rd_chk("frm before strobe", `E3RXO_ADDR_FRM_CNT, 16'h0000);
        fork
            far_end.burst(3'b100, 1);
            strobe();
        join
        rd_chk("frm count", `E3RXO_ADDR_FRM_CNT, 16'h0003);
        rd_chk("par count", `E3RXO_ADDR_PAR_CNT, 16'h0002);
        rd_chk("rei count", `E3RXO_ADDR_REI_CNT, 16'h0001);
        rd_chk("status", `E3RXO_ADDR_STATUS, 16'h07C7);
        $display("test counters done");
        reg_wr(`E3RXO_ADDR_MASK, 16'h0001);
        check("irq no summary", {15'h0000, IRQ}, 16'h0000);
        reg_wr(`E3RXO_ADDR_CTRL, 16'h0001);
        check("irq enabled", {15'h0000, IRQ}, 16'h0001);
        reg_wr(`E3RXO_ADDR_MASK, 16'h0000);
        check("irq masked", {15'h0000, IRQ}, 16'h0000);
        reg_wr(`E3RXO_ADDR_MASK, 16'h0001);
        reg_wr(`E3RXO_ADDR_STATUS, 16'h07C7);
        check("irq cleared", {15'h0000, IRQ}, 16'h0000);
        rd_chk("status cleared", `E3RXO_ADDR_STATUS, 16'h0000);
        $display("test interrupt done");
        strobe();
        rd_chk("frm kept event", `E3RXO_ADDR_FRM_CNT, 16'h0001);
        rd_chk("par restarted", `E3RXO_ADDR_PAR_CNT, 16'h0000);
        check("irq second strobe", {15'h0000, IRQ}, 16'h0001);
        $display("test restart done");
        // back to back strobes, event on the first
        fork
            far_end.burst(3'b100, 1);
            begin
                @(posedge CLK);
                MONITOR_LATCH_STROBE <= 1'b1;
                repeat (2) @(posedge CLK);
                MONITOR_LATCH_STROBE <= 1'b0;
            end
        join
        rd_chk("frm back to back", `E3RXO_ADDR_FRM_CNT, 16'h0001);
        rd_chk("par back to back", `E3RXO_ADDR_PAR_CNT, 16'h0000);
        $display("test back to back strobes done");
        // frozen while clock enable low
        @(posedge CLK);
        CE <= 1'b0;
        far_end.burst(3'b111, 1);
        strobe();
        reg_wr(`E3RXO_ADDR_MASK, 16'h0000);
        @(posedge CLK);
        CE <= 1'b1;
        rd_chk("frm frozen", `E3RXO_ADDR_FRM_CNT, 16'h0001);
        rd_chk("mask frozen", `E3RXO_ADDR_MASK, 16'h0001);
        strobe();
        rd_chk("frm no frozen events", `E3RXO_ADDR_FRM_CNT, 16'h0000);
        rd_chk("rei no frozen events", `E3RXO_ADDR_REI_CNT, 16'h0000);
        $display("test clock enable done");
        summarize();
    end
endmodule // e3_g832_rx_overhead_counters_tb_top
